/* common/csc_map.svh */
// Register offsets, field positions and reset values of the capacitive-sense sequencer
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH
// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define CSC_ADDR_CONFIG 8'haa
`define CSC_ADDR_CTRL 8'hb0
`define CSC_ADDR_IRQ_STAT 8'hb1
`define CSC_ADDR_IRQ_MASK 8'hb2
`define CSC_ADDR_SCAN_LO 8'hd2
`define CSC_ADDR_SCAN_HI 8'hd3
`define CSC_ADDR_FIRST 8'hdd
`define CSC_ADDR_LAST 8'hde
`define CSC_ADDR_MUX 8'hdf
// ------------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------------
`define CSC_NUM_CHAN 14
`define CSC_CHAN_W 5
`define CSC_ACC_W 7
`define CSC_CTRL_BUSY 4
`define CSC_CTRL_CONV 5
`define CSC_CTRL_SCAN 6
`define CSC_STAT_CONV 0
`define CSC_STAT_SCAN 1
`define CSC_SCAN_LO_W 8
`define CSC_SCAN_HI_W 6
// ------------------------------------------------------------------
// Reset values and constants
// ------------------------------------------------------------------
`define CSC_CFG_RESET 8'h00
`define CSC_CHAN_NONE 5'h1f
`define CSC_ACC_1 7'h01
`define CSC_ACC_4 7'h04
`define CSC_ACC_8 7'h08
`define CSC_ACC_16 7'h10
`define CSC_ACC_32 7'h20
`define CSC_ACC_64 7'h40
`endif

/* common/csc_pkg.sv */
// Types shared by the capacitive-sense sequencer modules
`include "csc_map.svh"
package csc_pkg;
    // ------------------------------------------------------------------
    // Start-of-conversion modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CSC_MODE_SW = 3'b000,
        CSC_MODE_T0 = 3'b001,
        CSC_MODE_T2 = 3'b010,
        CSC_MODE_T1 = 3'b011,
        CSC_MODE_T3 = 3'b100,
        CSC_MODE_RSV = 3'b101,
        CSC_MODE_CONT = 3'b110,
        CSC_MODE_SCAN = 3'b111
    } csc_mode_t;

    // Configuration register layout, bit 7 down to bit 0
    typedef struct packed {
        logic smen;
        csc_mode_t mode;
        logic mcen;
        logic [2:0] acu;
    } csc_cfg_t;

    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csc_bus_t;

    // Whole state of the top module
    typedef struct packed {
        csc_cfg_t cfg;
        logic [`CSC_NUM_CHAN-1:0] scan_mask;
        logic [`CSC_CHAN_W-1:0] first;
        logic [`CSC_CHAN_W-1:0] last;
        logic [`CSC_CHAN_W-1:0] mux;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic busy;
        logic cont;
        logic start;
        logic [`CSC_CHAN_W-1:0] cur;
        logic [7:0] rdata;
        logic irq;
        logic [`CSC_NUM_CHAN-1:0] conn;
    } csc_top_state_t;

    // State of the sample sequencer
    typedef struct packed {
        logic active;
        logic req;
        logic done;
        logic [`CSC_ACC_W-1:0] cnt;
    } csc_seq_state_t;
endpackage

/* hdl/csc_sample_seq.sv */
// Sample sequencer: requests front-end samples until the accumulation count is reached
`timescale 1ns/10ps
`default_nettype none
`include "csc_map.svh"
module csc_sample_seq
    import csc_pkg::*;
#(
    parameter int ACC_W = `CSC_ACC_W
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [ACC_W-1:0] target,
    input wire logic sample_done,
    output logic sample_req,
    output logic conv_done
);
    csc_seq_state_t s_reg;
    csc_seq_state_t s_next;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Only one sample is ever outstanding, so the count never overruns
    always_comb begin
        s_next = s_reg;
        s_next.req = 1'b0;
        s_next.done = 1'b0;
        if (start) begin
            s_next.active = 1'b1;
            s_next.cnt = '0;
            s_next.req = 1'b1;
        end else if (s_reg.active && sample_done) begin
            s_next.cnt = ACC_W'(s_reg.cnt + 1'b1);
            if (ACC_W'(s_reg.cnt + 1'b1) >= target) begin
                s_next.active = 1'b0;
                s_next.done = 1'b1;
            end else begin
                s_next.req = 1'b1;
            end
        end
    end

    // Register the whole state
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sample_req = s_reg.req;
    assign conv_done = s_reg.done;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    chk_sample_count: assert property (
        (s_reg.active && sample_done && !start && ACC_W'(s_reg.cnt + 1'b1) == target) |=> conv_done)
        else $error("Conversion did not finish at the accumulation count");
    cover_multi_sample: cover property (s_reg.active && sample_done && target > `CSC_ACC_1);
endmodule
`default_nettype wire

/* hdl/csc_sequencer.sv */
// Capacitive-sense conversion configuration and sequencing block
// What this block does
// - Masking off ignores both scan mask registers
// - Masking on selects scanned channels from masks
// - Mode 000 starts conversion on busy write
// - Modes 001-100 start on timer 0/2/1/3 overflow
// - Mode 110 converts muxed channel continuously
// - Accumulate 1/4/8/16/32/64 samples per result
// - Conversion done flag sets, held till cleared
// - Scan done flag sets, never auto-cleared
// - Busy reads one while converting
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "csc_map.svh"
module csc_sequencer
    import csc_pkg::*;
#(
    parameter int NCH = `CSC_NUM_CHAN
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] tmr_ovf,
    input wire logic afe_sample_done,
    output logic afe_sample_req,
    output logic [`CSC_CHAN_W-1:0] afe_chan_sel,
    output logic [NCH-1:0] afe_chan_connect,
    output logic irq
);
    csc_top_state_t s_reg;
    csc_top_state_t s_next;
    csc_bus_t bus;
    logic conv_done;
    logic [`CSC_ACC_W-1:0] acc_target;
    logic [NCH-1:0] range_mask;
    logic [`CSC_CHAN_W:0] step;

    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Samples per result; reserved codes fall back to one sample
    function automatic logic [`CSC_ACC_W-1:0] acc_count(input logic [2:0] code);
        unique case (code)
            3'h0: acc_count = `CSC_ACC_1;
            3'h1: acc_count = `CSC_ACC_4;
            3'h2: acc_count = `CSC_ACC_8;
            3'h3: acc_count = `CSC_ACC_16;
            3'h4: acc_count = `CSC_ACC_32;
            3'h5: acc_count = `CSC_ACC_64;
            default: acc_count = `CSC_ACC_1;
        endcase
    endfunction

    // Next scan channel, top bit flags a wrap back to the start
    function automatic logic [`CSC_CHAN_W:0] scan_step(
        input logic [`CSC_CHAN_W-1:0] cur,
        input logic smen,
        input logic [NCH-1:0] mask,
        input logic [`CSC_CHAN_W-1:0] first,
        input logic [`CSC_CHAN_W-1:0] last
    );
        logic found;
        logic [`CSC_CHAN_W-1:0] nxt;
        logic [`CSC_CHAN_W-1:0] low;
        found = 1'b0;
        nxt = cur;
        low = cur;
        // Walk downwards so the lowest qualifying channel wins
        for (int i = NCH - 1; i >= 0; i--) begin
            if (mask[i]) begin
                low = `CSC_CHAN_W'(i);
                if (`CSC_CHAN_W'(i) > cur) begin
                    nxt = `CSC_CHAN_W'(i);
                    found = 1'b1;
                end
            end
        end
        if (smen) begin
            scan_step = found ? {1'b0, nxt} : {1'b1, low};
        end else if (cur >= last || cur == `CSC_CHAN_NONE) begin
            scan_step = {1'b1, first};
        end else begin
            scan_step = {1'b0, `CSC_CHAN_W'(cur + 1'b1)};
        end
    endfunction

    // Channels first..last, used for merging while masking is off
    always_comb begin
        range_mask = '0;
        for (int i = 0; i < NCH; i++) begin
            range_mask[i] = (`CSC_CHAN_W'(i) >= s_reg.first) && (`CSC_CHAN_W'(i) <= s_reg.last);
        end
    end

    assign acc_target = acc_count(s_reg.cfg.acu);
    assign step = scan_step(s_reg.cur, s_reg.cfg.smen, s_reg.scan_mask, s_reg.first, s_reg.last);

    // ------------------------------------------------------------------
    // Next state: registers, triggers and channel sequencing
    // ------------------------------------------------------------------
    always_comb begin
        logic busy_wr;
        logic trig;
        logic [`CSC_CHAN_W:0] first_step;
        trig = 1'b0;
        s_next = s_reg;
        busy_wr = bus.wr && bus.addr == `CSC_ADDR_CTRL && bus.wdata[`CSC_CTRL_BUSY];
        first_step = scan_step(`CSC_CHAN_NONE, s_reg.cfg.smen, s_reg.scan_mask,
                               s_reg.first, s_reg.last);
        s_next.start = 1'b0;
        s_next.rdata = '0;
        // Register writes; status bits are write-one-to-clear
        if (bus.wr) begin
            unique case (bus.addr)
                `CSC_ADDR_CONFIG: s_next.cfg = csc_cfg_t'(bus.wdata);
                `CSC_ADDR_SCAN_LO: s_next.scan_mask[`CSC_SCAN_LO_W-1:0] = bus.wdata;
                `CSC_ADDR_SCAN_HI:
                    s_next.scan_mask[NCH-1:`CSC_SCAN_LO_W] = bus.wdata[`CSC_SCAN_HI_W-1:0];
                `CSC_ADDR_FIRST: s_next.first = bus.wdata[`CSC_CHAN_W-1:0];
                `CSC_ADDR_LAST: s_next.last = bus.wdata[`CSC_CHAN_W-1:0];
                `CSC_ADDR_MUX: s_next.mux = bus.wdata[`CSC_CHAN_W-1:0];
                `CSC_ADDR_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~bus.wdata[1:0];
                `CSC_ADDR_IRQ_MASK: s_next.irq_mask = bus.wdata[1:0];
                default: ;
            endcase
        end
        // Trigger selection by start mode
        unique case (s_reg.cfg.mode)
            CSC_MODE_SW: trig = busy_wr;
            CSC_MODE_T0: trig = tmr_ovf[0];
            CSC_MODE_T2: trig = tmr_ovf[2];
            CSC_MODE_T1: trig = tmr_ovf[1];
            CSC_MODE_T3: trig = tmr_ovf[3];
            CSC_MODE_CONT: trig = busy_wr;
            CSC_MODE_SCAN: trig = busy_wr;
            default: trig = 1'b0;
        endcase
        // Triggers while busy are dropped rather than queued
        if (!s_reg.busy && trig) begin
            s_next.busy = 1'b1;
            s_next.start = 1'b1;
            s_next.cont = s_reg.cfg.mode == CSC_MODE_CONT || s_reg.cfg.mode == CSC_MODE_SCAN;
            s_next.cur = s_reg.cfg.mode == CSC_MODE_SCAN ? first_step[`CSC_CHAN_W-1:0] : s_reg.mux;
        end
        // Completion: flag it, then stop or carry on
        if (conv_done) begin
            s_next.irq_stat[`CSC_STAT_CONV] = 1'b1;
            if (s_reg.cont && s_reg.cfg.mode == CSC_MODE_CONT) begin
                s_next.cur = s_reg.mux;
                s_next.start = 1'b1;
            end else if (s_reg.cont && s_reg.cfg.mode == CSC_MODE_SCAN) begin
                s_next.cur = step[`CSC_CHAN_W-1:0];
                s_next.start = 1'b1;
                // A merged conversion covers every channel of the merged set at once
                if (step[`CSC_CHAN_W] || s_reg.cfg.mcen) begin
                    s_next.irq_stat[`CSC_STAT_SCAN] = 1'b1;
                end
            end else begin
                s_next.busy = 1'b0;
                s_next.cont = 1'b0;
            end
        end
        // Sensing connection: merged set or the single current channel
        if (s_reg.cfg.mcen) begin
            s_next.conn = s_reg.cfg.smen ? s_reg.scan_mask : range_mask;
        end else begin
            s_next.conn = NCH'(1) << s_reg.cur;
        end
        if (!s_reg.busy) begin
            s_next.conn = '0;
        end
        // Read data stands in the cycle after the strobe
        if (bus.rd) begin
            unique case (bus.addr)
                `CSC_ADDR_CONFIG: s_next.rdata = s_reg.cfg;
                `CSC_ADDR_CTRL: begin
                    s_next.rdata[`CSC_CTRL_BUSY] = s_reg.busy;
                    s_next.rdata[`CSC_CTRL_CONV] = s_reg.irq_stat[`CSC_STAT_CONV];
                    s_next.rdata[`CSC_CTRL_SCAN] = s_reg.irq_stat[`CSC_STAT_SCAN];
                end
                `CSC_ADDR_IRQ_STAT: s_next.rdata[1:0] = s_reg.irq_stat;
                `CSC_ADDR_IRQ_MASK: s_next.rdata[1:0] = s_reg.irq_mask;
                `CSC_ADDR_SCAN_LO: s_next.rdata = s_reg.scan_mask[`CSC_SCAN_LO_W-1:0];
                `CSC_ADDR_SCAN_HI:
                    s_next.rdata[`CSC_SCAN_HI_W-1:0] = s_reg.scan_mask[NCH-1:`CSC_SCAN_LO_W];
                `CSC_ADDR_FIRST: s_next.rdata[`CSC_CHAN_W-1:0] = s_reg.first;
                `CSC_ADDR_LAST: s_next.rdata[`CSC_CHAN_W-1:0] = s_reg.last;
                `CSC_ADDR_MUX: s_next.rdata[`CSC_CHAN_W-1:0] = s_reg.mux;
                default: s_next.rdata = '0;
            endcase
        end
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    end

    // Register the whole state
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Sample sequencing
    // ------------------------------------------------------------------
    csc_sample_seq #(.ACC_W(`CSC_ACC_W)) u_seq (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(s_reg.start),
        .target(acc_target),
        .sample_done(afe_sample_done),
        .sample_req(afe_sample_req),
        .conv_done(conv_done)
    );

    assign reg_rdata = s_reg.rdata;
    assign afe_chan_sel = s_reg.cur;
    assign afe_chan_connect = s_reg.conn;
    assign irq = s_reg.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    chk_sw_start: assert property (
        (bus.wr && bus.addr == `CSC_ADDR_CTRL && bus.wdata[`CSC_CTRL_BUSY]
         && s_reg.cfg.mode == CSC_MODE_SW && !s_reg.busy) |=> (s_reg.busy && s_reg.start))
        else $error("Busy write did not start a conversion");
    chk_timer_start: assert property (
        (!bus.wr && !s_reg.busy && s_reg.cfg.mode == CSC_MODE_T2 && tmr_ovf[2])
        |=> s_reg.busy ##1 afe_sample_req)
        else $error("Timer 2 overflow did not start a conversion");
    chk_cont_again: assert property (
        (conv_done && s_reg.cont && s_reg.cfg.mode == CSC_MODE_CONT)
        |=> (s_reg.busy && s_reg.cur == $past(s_reg.mux)))
        else $error("Continuous mode did not restart on the muxed channel");
    chk_merge_mask: assert property (
        (s_reg.busy && s_reg.cfg.mcen && s_reg.cfg.smen && !bus.wr)
        |=> afe_chan_connect == $past(s_reg.scan_mask))
        else $error("Merged channels do not follow the scan masks");
    chk_merge_range: assert property (
        (s_reg.busy && s_reg.cfg.mcen && !s_reg.cfg.smen && !bus.wr)
        |=> afe_chan_connect == $past(range_mask))
        else $error("Masks were not ignored with masking off");
    chk_scan_wrap: assert property (
        (conv_done && s_reg.cont && s_reg.cfg.mode == CSC_MODE_SCAN && !s_reg.cfg.smen
         && s_reg.cur >= s_reg.last) |=> (s_reg.cur == $past(s_reg.first)))
        else $error("Scan did not wrap to the first channel");
    chk_conv_flag: assert property (conv_done |=> s_reg.irq_stat[`CSC_STAT_CONV])
        else $error("Conversion done flag not set");
    chk_scan_hold: assert property (
        (s_reg.irq_stat[`CSC_STAT_SCAN]
         && !(bus.wr && bus.addr == `CSC_ADDR_IRQ_STAT && bus.wdata[`CSC_STAT_SCAN]))
        |=> s_reg.irq_stat[`CSC_STAT_SCAN])
        else $error("Scan done flag cleared by itself");
    chk_busy_read: assert property (
        (bus.rd && bus.addr == `CSC_ADDR_CTRL) |=> reg_rdata[`CSC_CTRL_BUSY] == $past(s_reg.busy))
        else $error("Busy read does not match the conversion state");
    // The default disable would mask this check, since it fires only in reset
    chk_reset_cfg: assert property (
        @(posedge ref_clk) disable iff (1'b0) !nrst |=> s_reg.cfg == `CSC_CFG_RESET)
        else $error("Configuration not zero after reset");

    cover_sw_conv: cover property (s_reg.cfg.mode == CSC_MODE_SW && conv_done);
    cover_scan_end: cover property (s_reg.cfg.mode == CSC_MODE_SCAN && conv_done && step[`CSC_CHAN_W]);
    cover_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* testbench/csc_afe_model.sv */
// Behavioural model of the sensing front end that answers sample requests
`timescale 1ns/10ps
`default_nettype none
module csc_afe_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] lat,
    input wire logic sample_req,
    output logic sample_done
);
    logic [3:0] wait_reg;
    logic pend_reg;

    // ------------------------------------------------------------------
    // Sample timing
    // ------------------------------------------------------------------
    // One sample in flight at a time; the delay is set by the bench so that
    // both prompt and slow answers are exercised
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pend_reg <= 1'b0;
            wait_reg <= 4'h0;
            sample_done <= 1'b0;
        end else if (sample_req) begin
            pend_reg <= 1'b1;
            wait_reg <= lat;
            sample_done <= 1'b0;
        end else if (pend_reg && wait_reg == 4'h0) begin
            pend_reg <= 1'b0;
            sample_done <= 1'b1; // Single-cycle pulse
        end else begin
            if (pend_reg) begin
                wait_reg <= wait_reg - 4'h1;
            end
            sample_done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* testbench/csc_sequencer_test.sv */
// Self-checking bench of the capacitive-sense sequencer
`timescale 1ns/10ps
`default_nettype none
`include "csc_map.svh"
module csc_sequencer_test
    import csc_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] tmr_ovf = 4'h0;
    logic afe_sample_done;
    logic afe_sample_req;
    logic [4:0] afe_chan_sel;
    logic [13:0] afe_chan_connect;
    logic irq;
    logic [3:0] lat = 4'h4;
    logic [7:0] rd_val;
    logic [3:0] tbit[6] = '{4'h0, 4'h1, 4'h4, 4'h2, 4'h8, 4'h0};
    logic [4:0] chan_q[$];
    logic [13:0] conn_q[$];
    int fails = 0;
    int n_tests = 0;
    int n_req = 0;
    int cycles = 0;
    int base;

    // Clock at 40 MHz
    always #12.5 ref_clk = ~ref_clk;

    csc_sequencer i_dut (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr_ovf(tmr_ovf),
        .afe_sample_done(afe_sample_done), .afe_sample_req(afe_sample_req),
        .afe_chan_sel(afe_chan_sel), .afe_chan_connect(afe_chan_connect), .irq(irq)
    );
    csc_afe_model i_afe (
        .ref_clk(ref_clk), .nrst(nrst), .lat(lat),
        .sample_req(afe_sample_req), .sample_done(afe_sample_done)
    );

    // Log every sample request mid-cycle, where outputs are settled
    always @(negedge ref_clk) begin
        cycles++;
        if (afe_sample_req === 1'b1) begin
            n_req++;
            chan_q.push_back(afe_chan_sel);
            conn_q.push_back(afe_chan_connect);
        end
        if (cycles == 30000) begin
            fails++;
            $display("Error timeout expected idle seen running");
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        rd_val = reg_rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        rd(a);
        chk(what, rd_val, exp);
    endtask

    // Polls busy with a bounded count instead of a fixed wait
    task automatic wait_idle();
        int i;
        i = 0;
        rd(`CSC_ADDR_CTRL);
        while (rd_val[`CSC_CTRL_BUSY] !== 1'b0 && i < 300) begin
            rd(`CSC_ADDR_CTRL);
            i++;
        end
        chk("busy_clear", rd_val[`CSC_CTRL_BUSY], 1'b0);
    endtask

    task automatic pulse(input logic [3:0] b);
        @(posedge ref_clk);
        tmr_ovf <= b;
        @(posedge ref_clk);
        tmr_ovf <= 4'h0;
    endtask

    // Start a continuous mode, log four requests, stop it by mode change
    task automatic run(input logic [7:0] cfg, input int nchk, input logic [4:0] exp[4],
                       input logic [13:0] econn);
        int i;
        wr(`CSC_ADDR_IRQ_STAT, 8'h03);
        chan_q.delete();
        conn_q.delete();
        wr(`CSC_ADDR_CONFIG, cfg);
        wr(`CSC_ADDR_CTRL, 8'h10);
        i = 0;
        while (chan_q.size() < 4 && i < 2000) begin
            @(negedge ref_clk);
            i++;
        end
        wr(`CSC_ADDR_CONFIG, 8'h00);
        wait_idle();
        for (int k = 0; k < nchk; k++) begin
            chk("chan_order", chan_q[k], exp[k]);
        end
        chk("connect", conn_q[0], econn);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        rdchk(`CSC_ADDR_CONFIG, 8'h00, "config_reset");
        rdchk(`CSC_ADDR_CTRL, 8'h00, "ctrl_reset");
        rdchk(8'h00, 8'h00, "unmapped_read");
        wr(`CSC_ADDR_CONFIG, 8'hf5);
        rdchk(`CSC_ADDR_CONFIG, 8'hf5, "config_rw");
        $display("test reset done");
        // Software start, flag, interrupt and write-one clear
        wr(`CSC_ADDR_IRQ_MASK, 8'h03);
        wr(`CSC_ADDR_CONFIG, 8'h00);
        wr(`CSC_ADDR_CTRL, 8'h10);
        rdchk(`CSC_ADDR_CTRL, 8'h10, "busy_set");
        wait_idle();
        chk("one_request", n_req, 1);
        rdchk(`CSC_ADDR_IRQ_STAT, 8'h01, "conv_flag");
        chk("irq_set", irq, 1'b1);
        rdchk(`CSC_ADDR_CTRL, 8'h20, "conv_flag_held");
        wr(`CSC_ADDR_IRQ_STAT, 8'h01);
        rdchk(`CSC_ADDR_IRQ_STAT, 8'h00, "conv_clear");
        chk("irq_clear", irq, 1'b0);
        $display("test software start done");
        // Every defined accumulation code; firmware never programs reserved codes
        lat <= 4'h0;
        for (int c = 0; c < 6; c++) begin
            base = n_req;
            wr(`CSC_ADDR_CONFIG, c[7:0]);
            wr(`CSC_ADDR_CTRL, 8'h10);
            wait_idle();
            chk("acc_samples", 16'(n_req - base), (c == 0) ? 16'h1 : 16'(2 << c));
        end
        $display("test accumulation done");
        // Timer modes react to their own timer only; reserved mode is left unused
        lat <= 4'h2;
        for (int m = 1; m < 5; m++) begin
            base = n_req;
            wr(`CSC_ADDR_CONFIG, {1'b0, m[2:0], 4'h0});
            pulse(4'hf & ~tbit[m]);
            repeat (10) @(posedge ref_clk);
            chk("tmr_other", 16'(n_req - base), 16'h0);
            pulse(tbit[m]);
            wait_idle();
            chk("tmr_own", 16'(n_req - base), 16'h1);
        end
        $display("test timer start done");
        // Continuous single channel and the scan variants
        wr(`CSC_ADDR_MUX, 8'h06);
        wr(`CSC_ADDR_SCAN_LO, 8'h02);
        wr(`CSC_ADDR_SCAN_HI, 8'h02);
        wr(`CSC_ADDR_FIRST, 8'h02);
        wr(`CSC_ADDR_LAST, 8'h04);
        run(8'h60, 4, '{5'd6, 5'd6, 5'd6, 5'd6}, 14'h0040);
        rdchk(`CSC_ADDR_IRQ_STAT, 8'h01, "no_scan_flag");
        run(8'h70, 4, '{5'd2, 5'd3, 5'd4, 5'd2}, 14'h0004);
        rdchk(`CSC_ADDR_IRQ_STAT, 8'h03, "scan_flag");
        run(8'hf0, 4, '{5'd1, 5'd9, 5'd1, 5'd9}, 14'h0002);
        run(8'hf8, 0, '{5'd0, 5'd0, 5'd0, 5'd0}, 14'h0202);
        // Merge with masking off ties first..last and ignores the masks
        run(8'h78, 0, '{5'd0, 5'd0, 5'd0, 5'd0}, 14'h001c);
        $display("test continuous modes done");
        stop_test();
    end
endmodule
`default_nettype wire
